// [logic/udc_cfg.svh]
`ifndef UDC_CFG_SVH
`define UDC_CFG_SVH
// Register byte offsets on APB
`define UDC_OFS_CTRL      12'h000
`define UDC_OFS_OTGFLAGS  12'h004
`define UDC_OFS_DEVFLAGS  12'h008
`define UDC_OFS_ADDR      12'h00c
`define UDC_OFS_EPSEL     12'h010
`define UDC_OFS_EPRST     12'h014
`define UDC_OFS_EPCFG     12'h018
`define UDC_OFS_EPSTAT    12'h01c
// Control register fields
`define UDC_CTRL_ENABLE   0
`define UDC_CTRL_FREEZE   1
`define UDC_CTRL_DETACH   2
`define UDC_CTRL_LOWSPD   3
`define UDC_CTRL_WAKEIE   4
`define UDC_CTRL_RESET    8'h06
// OTG flag fields
`define UDC_OTG_SESS      0
`define UDC_OTG_VBUS      1
`define UDC_OTG_BCON      2
`define UDC_OTG_ROLE      3
`define UDC_OTG_HNP       4
`define UDC_OTG_STO       5
`define UDC_OTG_MASK      8'h3f
// Device flag fields
`define UDC_DEV_SUSP      0
`define UDC_DEV_WAKE      1
// Address register
`define UDC_ADDR_EN       7
// Endpoint config fields
`define UDC_EPCFG_EN      0
`define UDC_EPCFG_TOGRST  1
`define UDC_EPCFG_BANK    2
`define UDC_EPCFG_MEMORY_ALLOCATE   3
`define UDC_EPCFG_SZLO    4
// Times
`define UDC_CLK_MHZ       50
`define UDC_IDLE_US       3000
`define UDC_STO_US        150000
`define UDC_BCON_US       300000
`endif

// [logic/udc_pkg.sv]
package udc_pkg;
    typedef struct packed {
        logic [2:0] size;
        logic       memory_allocate;
        logic       bank;
        logic       toggle;
        logic       enable;
    } udc_epcfg_t;
    typedef struct packed {
        logic [3:0] state;
        logic [1:0] bankFill;
        logic       cfgValid;
    } udc_epstat_t;
    typedef enum logic [1:0] {LINK_ACTIVE, LINK_SUSPENDED} udc_link_t;
endpackage

// [logic/udc_core_ctrl.sv]
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "udc_cfg.svh"
module udc_core_ctrl
    import udc_pkg::*;
#(
    parameter int NUM_EP     = 7,
    parameter int EP0_MAX    = 64,
    parameter int EP1_MAX    = 256,
    parameter int EPN_MAX    = 64,
    parameter int MEM_BYTES  = 832,
    parameter int IDLE_CYC   = `UDC_IDLE_US * `UDC_CLK_MHZ,
    parameter int STO_CYC    = `UDC_STO_US * `UDC_CLK_MHZ,
    parameter int BCON_CYC   = `UDC_BCON_US * `UDC_CLK_MHZ
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        vbusPresent,
    input  wire logic        lineIdle,
    input  wire logic        busReset,
    input  wire logic        vbusReq,
    input  wire logic        peerConnect,
    input  wire logic        hnpError,
    input  wire logic        hnpSwap,
    input  wire logic        srpDetect,
    input  wire logic        hostMode,
    input  wire logic        tokenValid,
    input  wire logic [6:0]  tokenAddr,
    input  wire logic [2:0]  tokenEp,
    output logic             pullupDp,
    output logic             pullupDm,
    output logic             fullSpeed,
    output logic             clkRun,
    output logic             tokenAck,
    output logic [6:0]       epRunning
);
    localparam int IW = 24;
    logic [7:0]  ctrl_r;
    logic [5:0]  otg_r;
    logic [1:0]  dev_r;
    logic [6:0]  addr_r;
    logic        addrEn_r;
    logic [2:0]  epSel_r;
    udc_epcfg_t  epCfg_r [NUM_EP];
    udc_epstat_t epStat_r [NUM_EP];
    logic [IW-1:0] idleCnt_r;
    logic [IW-1:0] stoCnt_r;
    logic [IW-1:0] bconCnt_r;
    logic        idleHit;
    logic        stoHit;
    logic        bconHit;
    logic        wr;
    logic        rd;
    logic        ctrlEn;
    logic        run;
    logic [NUM_EP-1:0] epRstPulse;
    logic [5:0]  otgSet;
    logic [31:0] rdata;
    logic        mapped;
    udc_epcfg_t  wrCfg;

    assign wr     = psel && penable && pwrite;
    assign rd     = psel && !penable && !pwrite;
    assign ctrlEn = ctrl_r[`UDC_CTRL_ENABLE];
    assign run    = ctrlEn && !ctrl_r[`UDC_CTRL_FREEZE];
    assign wrCfg  = udc_epcfg_t'(pwdata[6:0]);

    // Zero-wait-state slave
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rd) begin
                prdata <= rdata;
            end
        end
    end

    always_comb begin
        rdata  = 32'h0;
        mapped = 1'b1;
        unique case (paddr)
            `UDC_OFS_CTRL:     rdata = {24'h0, ctrl_r};
            `UDC_OFS_OTGFLAGS: rdata = {26'h0, otg_r};
            `UDC_OFS_DEVFLAGS: rdata = {30'h0, dev_r};
            `UDC_OFS_ADDR:     rdata = {24'h0, addrEn_r, addr_r};
            `UDC_OFS_EPSEL:    rdata = {29'h0, epSel_r};
            `UDC_OFS_EPRST:    rdata = 32'h0;
            `UDC_OFS_EPCFG:    rdata = {25'h0, epCfg_r[epSel_r]};
            `UDC_OFS_EPSTAT:   rdata = {25'h0, epStat_r[epSel_r]};
            default:           mapped = 1'b0;
        endcase
    end

    // Control: reset leaves clock frozen and device detached
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= `UDC_CTRL_RESET;
        end else if (wr && paddr == `UDC_OFS_CTRL) begin
            ctrl_r <= {3'h0, pwdata[4:0]};
        end
    end

    // Inactivity and suspend/wake
    assign idleHit = idleCnt_r == IW'(IDLE_CYC - 1);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idleCnt_r <= '0;
            dev_r     <= 2'b00;
            fullSpeed <= 1'b1;
        end else if (!ctrlEn) begin
            idleCnt_r <= '0;
            dev_r     <= 2'b00;
            fullSpeed <= 1'b1;
        end else begin
            if (!lineIdle || !run) begin
                idleCnt_r <= '0;
            end else if (!idleHit) begin
                idleCnt_r <= idleCnt_r + IW'(1);
            end
            if (wr && paddr == `UDC_OFS_DEVFLAGS) begin
                dev_r <= dev_r & pwdata[1:0];
            end
            if (!lineIdle) begin
                // Resume detection works even when frozen
                dev_r[`UDC_DEV_WAKE] <= 1'b1;
                dev_r[`UDC_DEV_SUSP] <= 1'b0;
            end else if (run && idleCnt_r == IW'(IDLE_CYC - 2)) begin
                dev_r[`UDC_DEV_SUSP] <= 1'b1;
                dev_r[`UDC_DEV_WAKE] <= 1'b0;
                fullSpeed            <= 1'b1;
            end
            if (wr && paddr == `UDC_OFS_CTRL) begin
                fullSpeed <= !pwdata[`UDC_CTRL_LOWSPD];
            end
        end
    end

    // OTG timers
    assign stoHit  = stoCnt_r == IW'(STO_CYC - 1);
    assign bconHit = bconCnt_r == IW'(BCON_CYC - 1);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stoCnt_r  <= '0;
            bconCnt_r <= '0;
        end else begin
            if (!run || !dev_r[`UDC_DEV_SUSP] || stoHit) begin
                stoCnt_r <= '0;
            end else begin
                stoCnt_r <= stoCnt_r + IW'(1);
            end
            if (!run || !vbusReq || peerConnect || bconHit) begin
                bconCnt_r <= '0;
            end else begin
                bconCnt_r <= bconCnt_r + IW'(1);
            end
        end
    end

    always_comb begin
        otgSet = 6'h0;
        otgSet[`UDC_OTG_STO]  = run && stoHit;
        otgSet[`UDC_OTG_HNP]  = run && hnpError;
        otgSet[`UDC_OTG_ROLE] = run && hnpSwap;
        otgSet[`UDC_OTG_BCON] = run && bconHit;
        otgSet[`UDC_OTG_VBUS] = run && vbusReq && !vbusPresent;
        otgSet[`UDC_OTG_SESS] = run && hostMode && srpDetect;
    end

    // Mode bit is a firmware concern; swap only flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            otg_r <= 6'h0;
        end else if (!ctrlEn) begin
            otg_r <= 6'h0;
        end else if (wr && paddr == `UDC_OFS_OTGFLAGS) begin
            otg_r <= (otg_r & pwdata[5:0]) | otgSet;
        end else begin
            otg_r <= otg_r | otgSet;
        end
    end

    // Device address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_r   <= 7'h00;
            addrEn_r <= 1'b0;
        end else if (!ctrlEn || busReset) begin
            addr_r   <= 7'h00;
            addrEn_r <= 1'b0;
        end else if (wr && paddr == `UDC_OFS_ADDR) begin
            // Firmware stores address first, enables later
            addr_r   <= pwdata[6:0];
            addrEn_r <= pwdata[`UDC_ADDR_EN];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            epSel_r <= 3'h0;
        end else if (wr && paddr == `UDC_OFS_EPSEL) begin
            epSel_r <= pwdata[2:0];
        end
    end

    // Endpoints: one slice each
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : gEp
            localparam int MAXB = g == 0 ? EP0_MAX
                                : g == 1 ? EP1_MAX : EPN_MAX;
            logic selWr;
            logic [11:0] bytes;
            assign selWr = wr && paddr == `UDC_OFS_EPCFG
                           && epSel_r == 3'(g);
            assign epRstPulse[g] = wr && paddr == `UDC_OFS_EPRST
                                   && pwdata[g];
            // Size code n means 8 << n bytes, times the bank count
            assign bytes = 12'(8) << epCfg_r[g].size << epCfg_r[g].bank;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    epCfg_r[g] <= '0;
                end else if (!ctrlEn) begin
                    epCfg_r[g] <= '0;
                end else if (busReset && g != 0) begin
                    epCfg_r[g].enable <= 1'b0;
                    epCfg_r[g].toggle <= 1'b0;
                end else if (selWr) begin
                    epCfg_r[g] <= wrCfg;
                    if (!wrCfg.enable || wrCfg.toggle) begin
                        // Size, bank and allocation kept
                        epCfg_r[g].toggle <= 1'b0;
                    end
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    epStat_r[g] <= '0;
                end else if (!ctrlEn || !epCfg_r[g].enable
                             || epRstPulse[g]) begin
                    epStat_r[g].state    <= 4'h0;
                    epStat_r[g].bankFill <= 2'h0;
                    epStat_r[g].cfgValid <= epCfg_r[g].enable
                                            && ctrlEn
                                            && epStat_r[g].cfgValid;
                end else begin
                    epStat_r[g].cfgValid <= epCfg_r[g].memory_allocate
                        && bytes <= 12'(MAXB * 2)
                        && bytes <= 12'(MEM_BYTES);
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    epRunning[g] <= 1'b0;
                end else begin
                    epRunning[g] <= ctrlEn && epCfg_r[g].enable
                                    && !epRstPulse[g];
                end
            end
        end
    endgenerate

    // Token acceptance by address and endpoint
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tokenAck <= 1'b0;
        end else begin
            tokenAck <= run && tokenValid && tokenEp < 3'(NUM_EP)
                && tokenAddr == (addrEn_r ? addr_r : 7'h00)
                && epStat_r[tokenEp].cfgValid
                && epCfg_r[tokenEp].enable;
        end
    end

    // Pull-up follows detach, VBUS and speed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pullupDp <= 1'b0;
            pullupDm <= 1'b0;
            clkRun   <= 1'b0;
        end else begin
            pullupDp <= ctrlEn && !ctrl_r[`UDC_CTRL_DETACH]
                        && vbusPresent && fullSpeed;
            pullupDm <= ctrlEn && !ctrl_r[`UDC_CTRL_DETACH]
                        && vbusPresent && !fullSpeed;
            clkRun   <= run;
        end
    end

    AST_PULLUP_NEEDS_VBUS: assert property (@(posedge clk) disable iff (rst)
        $rose(pullupDp) |-> $past(vbusPresent)
            && !$past(ctrl_r[`UDC_CTRL_DETACH]))
        else $error("pull-up without vbus or while detached");
    AST_DETACH_DROPS: assert property (@(posedge clk) disable iff (rst)
        ctrl_r[`UDC_CTRL_DETACH] |=> !pullupDp && !pullupDm)
        else $error("pull-up stayed on while detached");
    AST_OTG_STICKY: assert property (@(posedge clk) disable iff (rst)
        (otg_r[`UDC_OTG_HNP] && ctrlEn
         && !(wr && paddr == `UDC_OFS_OTGFLAGS))
        |=> otg_r[`UDC_OTG_HNP])
        else $error("negotiation flag lost without clear");
    AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
        (ctrlEn && otgSet[`UDC_OTG_VBUS]) |=> otg_r[`UDC_OTG_VBUS])
        else $error("vbus flag set lost");
    AST_ADDR_CLR: assert property (@(posedge clk) disable iff (rst)
        busReset |=> !addrEn_r && addr_r == 7'h00)
        else $error("address enable survived bus reset");
    AST_EP0_KEPT: assert property (@(posedge clk) disable iff (rst)
        (busReset && ctrlEn && !(wr && paddr == `UDC_OFS_EPCFG))
        |=> epCfg_r[0] == $past(epCfg_r[0]) && !epCfg_r[1].enable)
        else $error("bus reset endpoint handling wrong");
    AST_WAKE_CLR_SUSP: assert property (@(posedge clk) disable iff (rst)
        (ctrlEn && !lineIdle) |=> dev_r == 2'b10 || !ctrlEn)
        else $error("wake did not clear suspend");
    AST_DISABLE_RESET: assert property (@(posedge clk) disable iff (rst)
        !ctrlEn |=> otg_r == 6'h0 && !addrEn_r && epCfg_r[2] == '0)
        else $error("disable did not reset controller");
    AST_EP_HELD: assert property (@(posedge clk) disable iff (rst)
        !epCfg_r[3].enable |=> epStat_r[3].state == 4'h0
            && epStat_r[3].bankFill == 2'h0)
        else $error("disabled endpoint not held in reset");
    AST_TOKEN_MATCH: assert property (@(posedge clk) disable iff (rst)
        tokenAck |-> $past(tokenValid) && $past(tokenAddr)
            == ($past(addrEn_r) ? $past(addr_r) : 7'h00))
        else $error("token acknowledged at a foreign address");
    AST_TOKEN_CFG: assert property (@(posedge clk) disable iff (rst)
        tokenAck |-> $past(epStat_r[tokenEp].cfgValid)
            && $past(epCfg_r[tokenEp].enable))
        else $error("token acknowledged on unconfigured endpoint");
    AST_EPRST_KEEPS: assert property (@(posedge clk) disable iff (rst)
        (epRstPulse[1] && ctrlEn && !busReset)
        |=> epCfg_r[1] == $past(epCfg_r[1]) && !epRunning[1]
            && epStat_r[1].bankFill == 2'h0)
        else $error("endpoint reset lost configuration");
    AST_FREEZE_STOPS: assert property (@(posedge clk) disable iff (rst)
        ctrl_r[`UDC_CTRL_FREEZE] |=> !clkRun)
        else $error("clock kept running while frozen");
endmodule // udc_core_ctrl

// [verif/udc_host_model.sv]
`timescale 1ns/1ps
module udc_host_model (
    input  wire logic       clk,
    output logic            lineIdle,
    output logic            busReset,
    output logic            tokenValid,
    output logic      [6:0] tokenAddr,
    output logic      [2:0] tokenEp
);
    // Bus starts busy so no suspend count runs behind the other tests
    initial begin
        lineIdle   = 1'b0;
        busReset   = 1'b0;
        tokenValid = 1'b0;
        tokenAddr  = 7'h00;
        tokenEp    = 3'h0;
    end
    // Token lines invert once released so a stale match cannot pass
    task automatic send_token(input logic [6:0] a, input logic [2:0] e);
        @(posedge clk);
        tokenValid <= 1'b1;
        tokenAddr  <= a;
        tokenEp    <= e;
        @(posedge clk);
        tokenValid <= 1'b0;
        tokenAddr  <= ~a;
        tokenEp    <= ~e;
    endtask
    task automatic bus_reset();
        @(posedge clk);
        busReset <= 1'b1;
        @(posedge clk);
        busReset <= 1'b0;
    endtask
    task automatic set_idle(input logic v);
        @(posedge clk);
        lineIdle <= v;
    endtask
endmodule // udc_host_model

// [verif/tb_udc_core_ctrl.sv]
`timescale 1ns/1ps
`include "udc_cfg.svh"
module tb_udc_core_ctrl;
    localparam int IDLE = 20;
    localparam int STO  = 30;
    localparam int BCON = 40;
    localparam logic [11:0] CT = `UDC_OFS_CTRL, OT = `UDC_OFS_OTGFLAGS;
    localparam logic [11:0] DV = `UDC_OFS_DEVFLAGS, AD = `UDC_OFS_ADDR;
    localparam logic [11:0] SL = `UDC_OFS_EPSEL, RS = `UDC_OFS_EPRST;
    localparam logic [11:0] CF = `UDC_OFS_EPCFG, ST = `UDC_OFS_EPSTAT;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, lastErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        vbusPresent, lineIdle, busReset, vbusReq, peerConnect;
    logic        hnpError, hnpSwap, srpDetect, hostMode, tokenValid;
    logic [6:0]  tokenAddr, epRunning;
    logic [2:0]  tokenEp;
    logic        pullupDp, pullupDm, fullSpeed, clkRun, tokenAck;
    int          failures, cmp_count;
    udc_core_ctrl #(.IDLE_CYC(IDLE), .STO_CYC(STO), .BCON_CYC(BCON))
    u_udc_core_ctrl (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vbusPresent(vbusPresent),
        .lineIdle(lineIdle), .busReset(busReset), .vbusReq(vbusReq),
        .peerConnect(peerConnect), .hnpError(hnpError), .hnpSwap(hnpSwap),
        .srpDetect(srpDetect), .hostMode(hostMode), .tokenValid(tokenValid),
        .tokenAddr(tokenAddr), .tokenEp(tokenEp), .pullupDp(pullupDp),
        .pullupDm(pullupDm), .fullSpeed(fullSpeed), .clkRun(clkRun),
        .tokenAck(tokenAck), .epRunning(epRunning));
    udc_host_model u_udc_host_model (.clk(clk), .lineIdle(lineIdle),
        .busReset(busReset), .tokenValid(tokenValid),
        .tokenAddr(tokenAddr), .tokenEp(tokenEp));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Waits on pready with a bound; a dead slave counts as a mismatch
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        q = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(exp, q);
    endtask
    // Ack may land on either of the two edges after the token is taken
    task automatic tok(input logic [6:0] a, input logic [2:0] e,
                       input logic exp);
        logic ack;
        u_udc_host_model.send_token(a, e);
        ack = 1'b0;
        repeat (2) begin
            @(posedge clk);
            ack = ack | (tokenAck === 1'b1);
        end
        chk(32'(exp), 32'(ack));
    endtask
    task automatic t_reset();
        rdc(CT, 32'h06);
        rdc(OT, 32'h0);
        rdc(AD, 32'h0);
        chk(32'h0, {30'h0, pullupDp, pullupDm});
        chk(32'h0, 32'(clkRun));
        apb(1'b0, 12'h020, 32'h0, r);
        chk(32'h1, 32'(lastErr));
        chk(32'h0, r);
    endtask
    task automatic t_attach();
        wr(CT, 32'h05);
        vbusPresent <= 1'b1;
        cyc(3);
        chk(32'h0, 32'(pullupDp));
        vbusPresent <= 1'b0;
        wr(CT, 32'h01);
        cyc(3);
        chk(32'h0, 32'(pullupDp));
        vbusPresent <= 1'b1;
        cyc(3);
        chk(32'h1, 32'(pullupDp));
        chk(32'h1, 32'(clkRun));
        wr(CT, 32'h09);
        cyc(3);
        chk(32'h1, {30'h0, pullupDp, pullupDm});
    endtask
    task automatic t_suspend();
        u_udc_host_model.set_idle(1'b1);
        cyc(IDLE + 5);
        rdc(DV, 32'h01);
        chk(32'h1, 32'(fullSpeed));
        rdc(OT, 32'h0);
        cyc(STO);
        rdc(OT, 32'h20);
        wr(OT, 32'h0);
        rdc(OT, 32'h0);
        wr(CT, 32'h03);
        u_udc_host_model.set_idle(1'b0);
        cyc(3);
        rdc(DV, 32'h02);
        chk(32'h0, 32'(clkRun));
        wr(CT, 32'h01);
    endtask
    task automatic t_otg();
        hostMode <= 1'b1;
        @(posedge clk);
        hnpError  <= 1'b1;
        @(posedge clk);
        hnpError  <= 1'b0;
        hnpSwap   <= 1'b1;
        @(posedge clk);
        hnpSwap   <= 1'b0;
        srpDetect <= 1'b1;
        @(posedge clk);
        srpDetect <= 1'b0;
        cyc(2);
        rdc(OT, 32'h19);
        rdc(CT, 32'h01);
        wr(OT, 32'hff);
        rdc(OT, 32'h19);
        wr(OT, 32'hef);
        rdc(OT, 32'h09);
        wr(OT, 32'h0);
        vbusPresent <= 1'b0;
        vbusReq <= 1'b1;
        cyc(3);
        rdc(OT, 32'h02);
        wr(OT, 32'h0);
        rdc(OT, 32'h02);
        vbusReq <= 1'b0;
        vbusPresent <= 1'b1;
        wr(OT, 32'h0);
        peerConnect <= 1'b0;
        vbusReq <= 1'b1;
        cyc(BCON - 12);
        rdc(OT, 32'h0);
        cyc(20);
        rdc(OT, 32'h04);
        vbusReq <= 1'b0;
        peerConnect <= 1'b1;
        wr(OT, 32'h0);
    endtask
    task automatic t_ep();
        wr(SL, 32'h0);
        wr(CF, 32'h39);
        wr(SL, 32'h1);
        wr(CF, 32'h3d);
        rdc(CF, 32'h3d);
        rdc(ST, 32'h01);
        wr(SL, 32'h0);
        rdc(CF, 32'h39);
        chk(32'h03, 32'(epRunning));
        wr(SL, 32'h1);
        wr(RS, 32'h02);
        cyc(3);
        rdc(CF, 32'h3d);
        chk(32'h03, 32'(epRunning));
        wr(SL, 32'h2);
        wr(CF, 32'h79);
        rdc(ST, 32'h0);
        wr(CF, 32'h78);
        rdc(CF, 32'h78);
        u_udc_host_model.bus_reset();
        cyc(3);
        chk(32'h01, 32'(epRunning));
    endtask
    task automatic t_addr();
        tok(7'h00, 3'h0, 1'b1);
        wr(AD, 32'h05);
        tok(7'h05, 3'h0, 1'b0);
        wr(AD, 32'h85);
        tok(7'h05, 3'h0, 1'b1);
        tok(7'h00, 3'h0, 1'b0);
        tok(7'h05, 3'h1, 1'b0);
        u_udc_host_model.bus_reset();
        rdc(AD, 32'h0);
        tok(7'h00, 3'h0, 1'b1);
        wr(AD, 32'h85);
        wr(CT, 32'h0);
        apb(1'b0, AD, 32'h0, r);
        chk(32'h0, r & 32'h80);
        chk(32'h0, {24'h0, clkRun, epRunning});
    endtask
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {vbusPresent, vbusReq, hnpError, hnpSwap, srpDetect} = '0;
        hostMode = 1'b0;
        peerConnect = 1'b1;
        lastErr = 1'b0;
        cyc(2);
        rst <= 1'b0;
        t_reset();
        t_attach();
        t_suspend();
        t_otg();
        t_ep();
        t_addr();
        final_report();
    end
    // Whole run needs a few hundred cycles; this bound is far beyond it
    initial begin
        #1000000;
        failures++;
        final_report();
    end
endmodule // tb_udc_core_ctrl
